// >>> core/smw_fifo.sv
// request buffer between port arbitration and the memory sequencer
`timescale 1ns/1ps
module smw_fifo
   import smw_pkg::*;
#(
   parameter int WIDTH = SMW_REQ_W,
   parameter int DEPTH = SMW_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("smw_fifo depth must be a power of two of at least 2");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [PW:0]      cnt_reg, cnt_next;
   logic             rdy_reg, rdy_next;
   logic             push, pop;

   assign push      = in_valid && rdy_reg && clk_en;
   assign pop       = out_ready && (cnt_reg != '0) && clk_en;
   assign in_ready  = rdy_reg;
   assign out_valid = cnt_reg != '0;
   assign out_data  = mem_reg[rd_reg];

   always_comb begin
      wr_next  = push ? wr_reg + 1'b1 : wr_reg;
      rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      rdy_next = cnt_next != DEPTH[PW:0];
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
         rdy_reg <= 1'b1;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
endmodule : smw_fifo

// >>> core/smw_pkg.sv
// constants, types and state set for the static memory write sequencer
package smw_pkg;
   // ***********************************************
   // widths
   // ***********************************************
   localparam int SMW_ADDR_W     = 28;
   localparam int SMW_DATA_W     = 32;
   localparam int SMW_BANKS      = 4;
   localparam int SMW_BANK_W     = 2;
   localparam int SMW_WEDLY_W    = 4;
   localparam int SMW_WAIT_W     = 5;
   localparam int SMW_TURN_W     = 5;
   localparam int SMW_CNT_W      = 5;
   localparam int SMW_FIFO_DEPTH = 32;
   localparam int SMW_REQ_W      = 1 + SMW_BANK_W + SMW_ADDR_W + SMW_DATA_W;
   // ***********************************************
   // limits and field positions
   // ***********************************************
   localparam logic [SMW_TURN_W-1:0] SMW_TURN_MAX = 5'h10;
   localparam int SMW_F_WDATA_LO = 0;
   localparam int SMW_F_ADDR_LO  = SMW_DATA_W;
   localparam int SMW_F_BANK_LO  = SMW_DATA_W + SMW_ADDR_W;
   localparam int SMW_F_WRITE    = SMW_REQ_W - 1;
   localparam logic [SMW_BANKS-1:0]  SMW_CS_IDLE  = 4'hf;
   localparam logic [SMW_CNT_W-1:0]  SMW_CNT_ONE  = 5'h01;
   // ***********************************************
   // sequencer states
   // ***********************************************
   typedef enum logic [3:0] {
      SMW_IDLE, SMW_PROC1, SMW_PROC2, SMW_TURN, SMW_ADDR, SMW_WEDLY,
      SMW_WEACT, SMW_WEOFF, SMW_CSOFF, SMW_RDADDR, SMW_RDRET
   } smw_state_e;
endpackage : smw_pkg

// >>> core/smw_wait_counter.sv
// shared down counter for delay, wait and turnaround phases
`timescale 1ns/1ps
module smw_wait_counter
   import smw_pkg::*;
(
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic                 clk_en,
   // control
   input  wire logic                 load,
   input  wire logic [SMW_CNT_W-1:0] load_val,
   input  wire logic                 dec,
   // status
   output logic                      zero
);
   logic [SMW_CNT_W-1:0] cnt_reg, cnt_next;

   assign zero = cnt_reg == '0;

   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = load_val;
      end else if (dec && cnt_reg != '0) begin
         cnt_next = cnt_reg - SMW_CNT_ONE;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
      end else if (clk_en) begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : smw_wait_counter

// >>> core/smw_write_turnaround.sv
// static memory write sequencer with per-bank bus turnaround
// What this block does
// [R1] fetch write data at arbitration, two processing cycles, then address and select, enable off
// [R2] write data driven cycle after select; enable asserts after the programmed delay cycles
// [R3] after enable active, deassert enable, then select and controls inactive next cycle
// [R4] identical write timing for any transfer kind or burst type
// [R5] every write spends at least one enable-on and one enable-off cycle
// [R6] second write word fetched one cycle after the first
// [R7] back-to-back write: next select the cycle after controls go inactive
// [R8] flash banks written exactly like sram banks
// [R9] per-bank turnaround count from 1 to 16 cycles
// [R10] turnaround after read before other-bank read or any write
// [R11] read then write keeps the pipeline gap even with zero turnaround
// [R12] enable follows select by 0 to 15 programmed delay cycles
// [R13] enable deasserts one cycle before select at end of write
// [R14] no turnaround after writes or between same-bank reads
`timescale 1ns/1ps
module smw_write_turnaround
   import smw_pkg::*;
#(
   parameter int FIFO_DEPTH = SMW_FIFO_DEPTH
) (
   // clock, enable and reset
   input  wire logic                             sys_clk,
   input  wire logic                             rstn,
   input  wire logic                             clk_en,
   // request port after arbitration
   input  wire logic                             req_valid,
   output logic                                  req_ready,
   input  wire logic                             req_write,
   input  wire logic [SMW_BANK_W-1:0]            req_bank,
   input  wire logic [SMW_ADDR_W-1:0]            req_addr,
   input  wire logic [SMW_DATA_W-1:0]            req_wdata,
   // read return
   output logic                                  rd_valid,
   output logic      [SMW_DATA_W-1:0]            rd_data,
   output logic                                  busy,
   // timing configuration
   input  wire logic [SMW_WEDLY_W-1:0]           we_delay_cycles,
   input  wire logic [SMW_WAIT_W-1:0]            write_wait_states,
   input  wire logic [SMW_WAIT_W-1:0]            read_wait_states,
   input  wire logic [SMW_BANKS*SMW_TURN_W-1:0]  turnaround_cycles,
   // static memory pins
   output logic      [SMW_BANKS-1:0]             static_chip_select_n,
   output logic                                  static_write_enable_n,
   output logic                                  static_output_enable_n,
   output logic      [SMW_ADDR_W-1:0]            static_addr,
   output logic      [SMW_DATA_W-1:0]            static_data_out,
   output logic                                  static_data_oe,
   input  wire logic [SMW_DATA_W-1:0]            static_data_in
);
   // ***********************************************
   // helpers
   // ***********************************************
   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("smw_write_turnaround needs a fifo depth of at least 2");
   end

   function automatic logic [SMW_TURN_W-1:0] turn_of(input logic [SMW_BANK_W-1:0] b,
                                                     input logic [SMW_BANKS*SMW_TURN_W-1:0] all);
      logic [SMW_TURN_W-1:0] t;
      t = all[b*SMW_TURN_W +: SMW_TURN_W];
      turn_of = (t > SMW_TURN_MAX) ? SMW_TURN_MAX : t;
   endfunction : turn_of

   function automatic logic need_turn(input logic last_rd, input logic [SMW_BANK_W-1:0] last_b,
                                      input logic wr, input logic [SMW_BANK_W-1:0] b);
      need_turn = last_rd && (wr || b != last_b);
   endfunction : need_turn

   // ***********************************************
   // request buffer
   // ***********************************************
   logic                 f_valid, f_pop;
   logic [SMW_REQ_W-1:0] f_data;
   logic                 h_write;
   logic [SMW_BANK_W-1:0] h_bank;

   // data is taken whenever the buffer has room, one word per cycle
   smw_fifo #(.WIDTH(SMW_REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .clk_en    (clk_en),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   ({req_write, req_bank, req_addr, req_wdata}),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   ); // R1 R6
   assign h_write = f_data[SMW_F_WRITE];
   assign h_bank  = f_data[SMW_F_BANK_LO +: SMW_BANK_W];

   // ***********************************************
   // sequencer state
   // ***********************************************
   smw_state_e            state_reg, state_next;
   logic                  cur_write_reg, cur_write_next;
   logic [SMW_BANK_W-1:0] cur_bank_reg, cur_bank_next;
   logic [SMW_ADDR_W-1:0] cur_addr_reg, cur_addr_next;
   logic [SMW_DATA_W-1:0] cur_wdata_reg, cur_wdata_next;
   logic                  last_rd_reg, last_rd_next;
   logic [SMW_BANK_W-1:0] last_bank_reg, last_bank_next;
   logic [SMW_BANKS-1:0]  cs_n_reg, cs_n_next;
   logic                  we_n_reg, we_n_next, oe_n_reg, oe_n_next;
   logic [SMW_ADDR_W-1:0] addr_reg, addr_next;
   logic [SMW_DATA_W-1:0] wdata_reg, wdata_next;
   logic                  doe_reg, doe_next;
   logic                  rv_reg, rv_next, busy_reg, busy_next;
   logic [SMW_DATA_W-1:0] rdata_reg, rdata_next;
   logic                  cnt_load, cnt_dec, cnt_zero, go_start;
   logic [SMW_CNT_W-1:0]  cnt_val;
   logic [SMW_TURN_W-1:0] tv;

   smw_wait_counter u_cnt (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .load     (cnt_load),
      .load_val (cnt_val),
      .dec      (cnt_dec),
      .zero     (cnt_zero)
   );

   // turnaround uses the setting of the bank that was read last
   assign tv = turn_of(last_bank_reg, turnaround_cycles); // R9

   always_comb begin
      state_next     = state_reg;
      cur_write_next = cur_write_reg;
      cur_bank_next  = cur_bank_reg;
      cur_addr_next  = cur_addr_reg;
      cur_wdata_next = cur_wdata_reg;
      last_rd_next   = last_rd_reg;
      last_bank_next = last_bank_reg;
      cs_n_next      = cs_n_reg;
      we_n_next      = we_n_reg;
      oe_n_next      = oe_n_reg;
      addr_next      = addr_reg;
      wdata_next     = wdata_reg;
      doe_next       = doe_reg;
      rdata_next     = rdata_reg;
      rv_next        = 1'b0;
      f_pop          = 1'b0;
      cnt_load       = 1'b0;
      cnt_dec        = 1'b0;
      cnt_val        = '0;
      go_start       = 1'b0;
      case (state_reg)
         SMW_IDLE: begin
            if (f_valid) begin
               f_pop      = 1'b1;
               state_next = SMW_PROC1;
            end
         end
         SMW_PROC1: begin
            state_next = SMW_PROC2; // R1
         end
         SMW_PROC2: begin
            if (need_turn(last_rd_reg, last_bank_reg, cur_write_reg, cur_bank_reg) && tv != '0) begin // R10 R14
               state_next = SMW_TURN;
               cnt_load   = 1'b1;
               cnt_val    = tv - 1'b1; // R9
            end else begin
               go_start = 1'b1; // R1
            end
         end
         SMW_TURN: begin
            if (cnt_zero) begin
               go_start = 1'b1;
            end else begin
               cnt_dec = 1'b1; // R9
            end
         end
         SMW_ADDR: begin
            doe_next = 1'b1; // R2
            if (we_delay_cycles == '0) begin
               state_next = SMW_WEACT;
               we_n_next  = 1'b0; // R12
               cnt_load   = 1'b1;
               cnt_val    = write_wait_states;
            end else begin
               state_next = SMW_WEDLY;
               cnt_load   = 1'b1;
               cnt_val    = {1'b0, we_delay_cycles - 1'b1}; // R2 R12
            end
         end
         SMW_WEDLY: begin
            if (cnt_zero) begin
               state_next = SMW_WEACT;
               we_n_next  = 1'b0; // R2
               cnt_load   = 1'b1;
               cnt_val    = write_wait_states;
            end else begin
               cnt_dec = 1'b1;
            end
         end
         SMW_WEACT: begin
            if (cnt_zero) begin
               state_next = SMW_WEOFF;
               we_n_next  = 1'b1; // R3 R5 R13
            end else begin
               cnt_dec = 1'b1;
            end
         end
         SMW_WEOFF: begin
            state_next     = SMW_CSOFF;
            cs_n_next      = SMW_CS_IDLE; // R3 R13
            doe_next       = 1'b0;
            last_rd_next   = 1'b0; // R14
            last_bank_next = cur_bank_reg;
         end
         SMW_CSOFF: begin
            if (f_valid) begin
               f_pop = 1'b1;
               if (h_write) begin
                  go_start = 1'b1; // R7
               end else begin
                  state_next = SMW_PROC1;
               end
            end else begin
               state_next = SMW_IDLE;
            end
         end
         SMW_RDADDR: begin
            if (cnt_zero) begin
               state_next = SMW_RDRET;
               cs_n_next  = SMW_CS_IDLE;
               oe_n_next  = 1'b1;
               rdata_next = static_data_in;
               rv_next    = 1'b1;
            end else begin
               cnt_dec = 1'b1;
            end
         end
         SMW_RDRET: begin
            state_next     = SMW_IDLE; // R11
            last_rd_next   = 1'b1;
            last_bank_next = cur_bank_reg;
         end
         default: begin
            state_next = SMW_IDLE;
         end
      endcase
      if (f_pop) begin
         cur_write_next = h_write;
         cur_bank_next  = h_bank;
         cur_addr_next  = f_data[SMW_F_ADDR_LO +: SMW_ADDR_W];
         cur_wdata_next = f_data[SMW_F_WDATA_LO +: SMW_DATA_W];
      end
      // same pin sequence for every bank type and transfer kind
      if (go_start) begin
         cs_n_next         = SMW_CS_IDLE;
         cs_n_next[cur_bank_next] = 1'b0; // R4 R8
         addr_next  = cur_addr_next;
         wdata_next = cur_wdata_next;
         we_n_next  = 1'b1; // R1
         if (cur_write_next) begin
            state_next = SMW_ADDR;
         end else begin
            state_next = SMW_RDADDR;
            oe_n_next  = 1'b0;
            cnt_load   = 1'b1;
            cnt_val    = read_wait_states;
         end
      end
      busy_next = state_next != SMW_IDLE;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= SMW_IDLE;
         cur_write_reg <= 1'b0;
         cur_bank_reg  <= '0;
         cur_addr_reg  <= '0;
         cur_wdata_reg <= '0;
         last_rd_reg   <= 1'b0;
         last_bank_reg <= '0;
         cs_n_reg      <= SMW_CS_IDLE;
         we_n_reg      <= 1'b1;
         oe_n_reg      <= 1'b1;
         addr_reg      <= '0;
         wdata_reg     <= '0;
         doe_reg       <= 1'b0;
         rdata_reg     <= '0;
         rv_reg        <= 1'b0;
         busy_reg      <= 1'b0;
      end else if (clk_en) begin
         state_reg     <= state_next;
         cur_write_reg <= cur_write_next;
         cur_bank_reg  <= cur_bank_next;
         cur_addr_reg  <= cur_addr_next;
         cur_wdata_reg <= cur_wdata_next;
         last_rd_reg   <= last_rd_next;
         last_bank_reg <= last_bank_next;
         cs_n_reg      <= cs_n_next;
         we_n_reg      <= we_n_next;
         oe_n_reg      <= oe_n_next;
         addr_reg      <= addr_next;
         wdata_reg     <= wdata_next;
         doe_reg       <= doe_next;
         rdata_reg     <= rdata_next;
         rv_reg        <= rv_next;
         busy_reg      <= busy_next;
      end
   end

   assign static_chip_select_n   = cs_n_reg;
   assign static_write_enable_n  = we_n_reg;
   assign static_output_enable_n = oe_n_reg;
   assign static_addr            = addr_reg;
   assign static_data_out        = wdata_reg;
   assign static_data_oe         = doe_reg;
   assign rd_valid               = rv_reg;
   assign rd_data                = rdata_reg;
   assign busy                   = busy_reg;

   // ***********************************************
   // checks
   // ***********************************************
   logic [SMW_CNT_W-1:0] we_age_reg, turn_age_reg;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         we_age_reg   <= '0;
         turn_age_reg <= '0;
      end else if (clk_en) begin
         we_age_reg   <= (state_reg == SMW_ADDR) ? SMW_CNT_ONE : we_age_reg + SMW_CNT_ONE;
         turn_age_reg <= (state_reg == SMW_TURN) ? turn_age_reg + SMW_CNT_ONE : SMW_CNT_ONE;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn || !clk_en);

   chk_proc_two_cycles: assert property ((state_reg == SMW_PROC1) |=> (state_reg == SMW_PROC2)) // R1
      else $error("processing phase not two cycles");
   chk_addr_we_off: assert property ((state_reg == SMW_ADDR) |-> we_n_reg && !(&cs_n_reg)) // R1
      else $error("address phase without select or with enable");
   chk_data_after_cs: assert property ((state_reg == SMW_ADDR) |=> doe_reg && !(&cs_n_reg)) // R2
      else $error("write data not driven after select");
   chk_we_delay_count: assert property ($fell(we_n_reg) |-> we_age_reg == {1'b0, we_delay_cycles} + SMW_CNT_ONE) // R12
      else $error("write enable delay wrong");
   chk_we_before_cs: assert property ($rose(we_n_reg) |-> !(&cs_n_reg) ##1 (&cs_n_reg)) // R13
      else $error("select not released one cycle after enable");
   chk_write_two_cycles: assert property ($fell(we_n_reg) |-> (!(&cs_n_reg)) [*2]) // R5
      else $error("write shorter than two cycles");
   chk_ctrl_off: assert property ((state_reg == SMW_WEOFF) |=> (&cs_n_reg) && we_n_reg && !doe_reg) // R3
      else $error("controls not released after write");
   chk_b2b_select: assert property ((state_reg == SMW_CSOFF && f_valid && h_write)
                                    |=> (!(&cs_n_reg) && we_n_reg) ##1 (we_n_reg == (we_delay_cycles != '0))) // R7
      else $error("back to back write select late");
   chk_turn_length: assert property ((state_reg == SMW_TURN && state_next != SMW_TURN)
                                     |-> turn_age_reg == tv) // R9
      else $error("turnaround length wrong");
   chk_turn_cause: assert property ((state_reg == SMW_TURN)
                                    |-> last_rd_reg && (cur_write_reg || cur_bank_reg != last_bank_reg)) // R10 R14
      else $error("turnaround without read before it");
   chk_read_gap: assert property ((state_reg == SMW_RDRET) |=> (&cs_n_reg) ##1 (&cs_n_reg)) // R11
      else $error("read followed too closely");
endmodule : smw_write_turnaround

// >>> sim/smw_static_mem.sv
// behavioural static memory banks on the far side of the sequencer pins
`timescale 1ns/1ps
module smw_static_mem
   import smw_pkg::*;
(
   // clock
   input  wire logic                  sys_clk,
   // memory pins
   input  wire logic [SMW_BANKS-1:0]  cs_n,
   input  wire logic                  we_n,
   input  wire logic                  oe_n,
   input  wire logic [SMW_ADDR_W-1:0] addr,
   input  wire logic [SMW_DATA_W-1:0] din,
   input  wire logic                  din_oe,
   output logic      [SMW_DATA_W-1:0] dout
);
   logic [SMW_DATA_W-1:0] mem [int];
   logic [SMW_DATA_W-1:0] last_reg;
   int                    key;
   initial last_reg = 32'h5a5a5a5a;
   always @* begin
      key = 0;
      for (int i = 0; i < SMW_BANKS; i++) if (!cs_n[i]) key = (i << SMW_ADDR_W) | int'(addr);
   end
   // store while enable is low, last enabled cycle wins
   always @(negedge sys_clk) begin
      if (!we_n && cs_n != SMW_CS_IDLE && din_oe) mem[key] = din;
   end
   // undriven data lines keep toggling so stale data never matches
   always @(posedge sys_clk) last_reg <= dout;
   always @* begin
      if (cs_n != SMW_CS_IDLE && !oe_n && mem.exists(key)) dout = mem[key];
      else dout = ~last_reg;
   end
endmodule : smw_static_mem

// >>> sim/smw_write_turnaround_bench.sv
// self-checking bench for the static memory write sequencer
`timescale 1ns/1ps
module smw_write_turnaround_bench;
   import smw_pkg::*;
   // ***********************************************
   // signals and bookkeeping
   // ***********************************************
   logic                            sys_clk, rstn, clk_en, req_valid, req_write;
   logic                            req_ready, rd_valid, busy, we_n, oe_n, data_oe;
   logic [SMW_BANK_W-1:0]           req_bank;
   logic [SMW_ADDR_W-1:0]           req_addr, mem_addr;
   logic [SMW_DATA_W-1:0]           req_wdata, rd_data, data_out, data_in;
   logic [SMW_WEDLY_W-1:0]          dly;
   logic [SMW_WAIT_W-1:0]           wst, rst;
   logic [SMW_BANKS*SMW_TURN_W-1:0] turn;
   logic [SMW_BANKS-1:0]            cs_n;
   logic [SMW_DATA_W-1:0]           shadow [logic [29:0]];
   logic [SMW_DATA_W-1:0]           exp_q [$];
   logic [29:0]                     keys [48];
   int num_errors, checked, seed, gap, cs_cnt, we_at, we_len, idle_cnt, full_seen, g, base;
   bit tmg;
   int kw1 [6] = '{0, 0, 0, 1, 1, 0};
   int kb2 [6] = '{1, 2, 1, 1, 2, 3};
   int kw2 [6] = '{1, 0, 0, 0, 1, 1};
   int kad [6] = '{1, 1, 0, 0, 0, 1};
   int tv [5] = '{0, 1, 7, 16, 20};
   smw_write_turnaround smw_write_turnaround_i (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank),
      .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
      .we_delay_cycles(dly), .write_wait_states(wst), .read_wait_states(rst), .turnaround_cycles(turn),
      .static_chip_select_n(cs_n), .static_write_enable_n(we_n), .static_output_enable_n(oe_n),
      .static_addr(mem_addr), .static_data_out(data_out), .static_data_oe(data_oe),
      .static_data_in(data_in));
   smw_static_mem smw_static_mem_i (.sys_clk(sys_clk), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
      .addr(mem_addr), .din(data_out), .din_oe(data_oe), .dout(data_in));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // ***********************************************
   // helpers
   // ***********************************************
   function automatic int turn_add(input int t);
      return (t > 16) ? 16 : t;
   endfunction : turn_add
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic send(input logic w, input logic [1:0] b, input logic [27:0] a, input logic [31:0] d);
      req_valid = 1'b1;
      req_write = w;
      req_bank = b;
      req_addr = a;
      req_wdata = d;
      if (w) shadow[{b, a}] = d;
      else exp_q.push_back(shadow[{b, a}]);
      clk_en = tmg | 1'($random(seed));
      while (!(req_ready === 1'b1 && clk_en)) begin
         if (req_ready !== 1'b1) full_seen++;
         @(negedge sys_clk);
         clk_en = tmg | 1'($random(seed));
      end
      @(negedge sys_clk);
   endtask : send
   task automatic drain();
      int q;
      req_valid = 1'b0;
      clk_en = 1'b1;
      q = 0;
      while (q < 4) begin
         @(negedge sys_clk);
         q = (busy === 1'b0) ? q + 1 : 0;
      end
   endtask : drain
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   // ***********************************************
   // pin monitor
   // ***********************************************
   always @(negedge sys_clk) begin
      if (rd_valid === 1'b1 && tmg) check("read data", rd_data, exp_q.pop_front());
      if (cs_n !== SMW_CS_IDLE) begin
         if (cs_cnt == 0) gap = idle_cnt;
         if (we_n === 1'b0) begin
            if (we_len == 0) we_at = cs_cnt;
            we_len++;
         end
         cs_cnt++;
         idle_cnt = 0;
      end else begin
         if (we_len != 0 && tmg) begin
            check("enable delay", we_at, dly + 1);
            check("enable width", we_len, wst + 1);
            check("select length", cs_cnt, dly + wst + 3);
         end
         cs_cnt = 0;
         we_len = 0;
         idle_cnt++;
      end
   end
   initial begin
      #(20 * 40000);
      num_errors++;
      test_done();
   end
   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      seed = 32'h4fb3;
      {rstn, clk_en, req_valid, req_write, req_bank, req_addr, req_wdata} = '0;
      {dly, wst, rst, turn} = '0;
      tmg = 1'b1;
      repeat (20) @(negedge sys_clk);
      rstn = 1'b1;
      clk_en = 1'b1;
      @(negedge sys_clk);
      send(1'b1, 2'h1, 28'h10, 32'h1234abcd);
      req_valid = 1'b0;
      g = 1;
      while (cs_n === SMW_CS_IDLE && g < 20) begin
         @(negedge sys_clk);
         g++;
      end
      check("select latency", g, 4);
      for (int b = 2; b < 4; b++) send(1'b1, 2'(b), 28'h10, $random(seed));
      drain();
      for (int k = 0; k < 6; k++) begin
         for (int i = 0; i < 5; i++) begin
            turn = {5'h3, 5'h3, 5'(tv[i]), 5'h3};
            send(1'(kw1[k]), 2'h1, 28'h10, $random(seed));
            send(1'(kw2[k]), 2'(kb2[k]), 28'h10, $random(seed));
            drain();
            if (i == 0) base = gap;
            check("turnaround", gap - base, kad[k] ? turn_add(tv[i]) : 0);
            if (k == 4) check("write to write gap", gap, 1);
         end
         if (k == 0) check("read to write gap", base >= 2, 1);
      end
      for (int bt = 0; bt < 6; bt++) begin
         dly = (bt < 2) ? 4'(bt * 15) : 4'($random(seed));
         wst = 5'($random(seed) & 3);
         rst = 5'($random(seed) & 3);
         turn = 20'($random(seed));
         tmg = (bt != 5);
         for (int j = 0; j < 48; j++) begin
            keys[j] = 30'($random(seed));
            send(1'b1, keys[j][29:28], keys[j][27:0], $random(seed));
         end
         drain();
         tmg = 1'b1;
         foreach (keys[j]) send(1'b0, keys[j][29:28], keys[j][27:0], '0);
         drain();
      end
      check("fifo refused", full_seen > 0, 1);
      check("reads outstanding", exp_q.size(), 0);
      test_done();
   end
endmodule : smw_write_turnaround_bench
